/* File: shared/dcfhp_params.svh */
// Purpose: constants of the dual channel filter host port
// Assumes: included by its bare name
// Notes: access sizes and key byte codes are shared by host and port
`ifndef DCFHP_PARAMS_SVH
`define DCFHP_PARAMS_SVH
`define DCFHP_SZ8 2'h0
`define DCFHP_SZ16 2'h1
`define DCFHP_SZ24 2'h2
`define DCFHP_KEY_LOW 2'h0
`define DCFHP_KEY_MID 2'h1
`define DCFHP_KEY_HIGH 2'h2
`define DCFHP_KEY_RST 2'h2
`define DCFHP_CHANNEL_IRQ_MASK_A 8'h01
`define DCFHP_CHANNEL_IRQ_MASK_B 8'h02
`define DCFHP_ALL_CHANNELS_IRQ_MASK 8'h03
`define DCFHP_CFG_CYCLES 1
`endif

/* File: shared/dcfhp_pkg.sv */
// Purpose: types of the dual channel filter host port
// Assumes: nothing
// Notes: one packed state struct per module
package dcfhp_pkg;
   typedef enum logic [1:0] {ST_OFF, ST_CFG, ST_RUN} dcfhp_state_t;
   typedef struct packed {
      logic [23:0] stage;
      logic [23:0] hold;
      logic [1:0] key;
      logic flag;
      logic [23:0] sample;
      logic vld;
   } dcfhp_chan_t;
   typedef struct packed {
      dcfhp_state_t st;
      logic [31:0] rdata;
      logic rvalid;
      logic [1:0] irq_en;
      logic [1:0] dma_en;
      logic init_done;
   } dcfhp_top_t;
endpackage

/* File: design/dcfhp_chan.sv */
// Purpose: one channel: staging, holding, key byte and data-ready flag
// Assumes: all strobes are one-cycle pulses on clk
// Notes: staging bytes not written keep their value
`timescale 1ns/1ps
`include "dcfhp_params.svh"
module dcfhp_chan
   import dcfhp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic run,
   input wire logic wr,
   input wire logic [1:0] size,
   input wire logic [23:0] wdata,
   input wire logic key_wr,
   input wire logic [1:0] key_sel,
   input wire logic clr,
   input wire logic res_load,
   input wire logic [23:0] res_data,
   output logic [23:0] hold,
   output logic flag,
   output logic [23:0] sample,
   output logic sample_valid
);
   dcfhp_chan_t s_reg, s_next;
   logic [2:0] be;
   logic key_hit;

   always_comb begin
      be = 3'h0;
      if (wr) begin
         case (size)
            `DCFHP_SZ8: be = 3'h4;
            `DCFHP_SZ16: be = 3'h6;
            `DCFHP_SZ24: be = 3'h7;
            default: be = 3'h0;
         endcase
      end
      key_hit = be[s_reg.key];
      s_next = s_reg;
      s_next.vld = 1'b0;
      if (be == 3'h4) begin
         s_next.stage[23:16] = wdata[7:0];
      end else if (be == 3'h6) begin
         s_next.stage[23:8] = wdata[15:0];
      end else if (be == 3'h7) begin
         s_next.stage = wdata;
      end
      // a write reaches the engine only when it covers the key byte; sign is passed untouched
      if (key_hit && run) begin
         s_next.sample = s_next.stage;
         s_next.vld = 1'b1;
      end
      if (key_wr && key_sel != 2'h3) begin
         s_next.key = key_sel;
      end
      if (clr) begin
         s_next.flag = 1'b0;
      end
      // a result arriving on a clear still sets the flag
      if (res_load && run) begin
         s_next.hold = res_data;
         s_next.flag = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '{stage: 24'h0, hold: 24'h0, key: `DCFHP_KEY_RST, flag: 1'b0,
                    sample: 24'h0, vld: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign hold = s_reg.hold;
   assign flag = s_reg.flag;
   assign sample = s_reg.sample;
   assign sample_valid = s_reg.vld;

   key_hands_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && size == `DCFHP_SZ8 && s_reg.key == `DCFHP_KEY_HIGH && run)
      |=> (sample_valid && sample[23:16] == $past(wdata[7:0])))
      else $error("key byte write did not hand over sample");
   low_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && size == `DCFHP_SZ8) |=> (s_reg.stage[15:0] == $past(s_reg.stage[15:0])))
      else $error("byte write disturbed lower bytes");
   load_flag_a: assert property (@(posedge clk) disable iff (sys_rst)
      (res_load && run) |=> (flag && hold == $past(res_data)))
      else $error("result load did not set flag");
   no_partial_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr && size == `DCFHP_SZ8 && s_reg.key == `DCFHP_KEY_LOW) |=> !sample_valid)
      else $error("partial write handed to engine");
endmodule

/* File: design/dcfhp_top.sv */
// Purpose: host sample access port of a two-channel filter engine
// Assumes: host and engine strobes are one-cycle pulses on clk
// Notes: read results are zero extended into host_rdata
`timescale 1ns/1ps
`include "dcfhp_params.svh"
module dcfhp_top
   import dcfhp_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start_cmd,
   input wire logic stop_cmd,
   input wire logic [1:0] cfg_irq_en,
   input wire logic [1:0] cfg_dma_en,
   input wire logic host_chan,
   input wire logic host_sel_status,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [1:0] host_size,
   input wire logic [31:0] host_wdata,
   input wire logic key_wr,
   input wire logic [1:0] key_sel,
   input wire logic [1:0] res_load,
   input wire logic [23:0] res_data_a,
   input wire logic [23:0] res_data_b,
   output logic [31:0] host_rdata,
   output logic host_rvalid,
   output logic [23:0] sample_a,
   output logic [23:0] sample_b,
   output logic [1:0] sample_valid,
   output logic [1:0] data_ready,
   output logic [1:0] irq_enable,
   output logic [1:0] dma_enable,
   output logic engine_enable,
   output logic engine_power_down,
   output logic init_done_indicator
);
   dcfhp_top_t s_reg, s_next;
   logic run;
   logic [1:0] clr;
   logic [23:0] hold [2];
   logic [23:0] samp [2];
   logic [23:0] res [2];
   logic [1:0] flag;
   logic [23:0] sel_hold;

   assign run = (s_reg.st == ST_RUN);
   assign res[0] = res_data_a;
   assign res[1] = res_data_b;

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : gen_ch
         logic [7:0] my_mask;
         assign my_mask = (g == 0) ? `DCFHP_CHANNEL_IRQ_MASK_A : `DCFHP_CHANNEL_IRQ_MASK_B;
         assign clr[g] = host_wr && host_sel_status && ((host_wdata[7:0] & my_mask) != 8'h0);
         dcfhp_chan u_chan (
            .clk(clk),
            .sys_rst(sys_rst),
            .run(run),
            .wr(host_wr && !host_sel_status && (host_chan == 1'(g))),
            .size(host_size),
            .wdata(host_wdata[23:0]),
            .key_wr(key_wr && (host_chan == 1'(g))),
            .key_sel(key_sel),
            .clr(clr[g]),
            .res_load(res_load[g]),
            .res_data(res[g]),
            .hold(hold[g]),
            .flag(flag[g]),
            .sample(samp[g]),
            .sample_valid(sample_valid[g])
         );
      end
   endgenerate

   assign sel_hold = host_chan ? hold[1] : hold[0];

   always_comb begin
      s_next = s_reg;
      s_next.rvalid = host_rd;
      if (host_rd) begin
         if (host_sel_status) begin
            s_next.rdata = {30'h0, flag};
         end else begin
            case (host_size)
               `DCFHP_SZ8: s_next.rdata = {24'h0, sel_hold[23:16]};
               `DCFHP_SZ16: s_next.rdata = {16'h0, sel_hold[23:8]};
               `DCFHP_SZ24: s_next.rdata = {8'h0, sel_hold};
               default: s_next.rdata = 32'h0;
            endcase
         end
      end
      case (s_reg.st)
         ST_OFF: begin
            if (start_cmd && !stop_cmd) begin
               s_next.irq_en = cfg_irq_en;
               s_next.dma_en = cfg_dma_en;
               s_next.init_done = 1'b1;
               s_next.st = ST_CFG;
            end
         end
         ST_CFG: begin
            // settings are in place a cycle before the engine runs
            s_next.st = stop_cmd ? ST_OFF : ST_RUN;
         end
         ST_RUN: begin
            if (stop_cmd) begin
               s_next.st = ST_OFF;
            end
         end
         default: s_next.st = ST_OFF;
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg <= '{st: ST_OFF, rdata: 32'h0, rvalid: 1'b0, irq_en: 2'h0,
                    dma_en: 2'h0, init_done: 1'b0};
      end else begin
         s_reg <= s_next;
      end
   end

   assign host_rdata = s_reg.rdata;
   assign host_rvalid = s_reg.rvalid;
   assign sample_a = samp[0];
   assign sample_b = samp[1];
   assign data_ready = flag;
   assign irq_enable = s_reg.irq_en;
   assign dma_enable = s_reg.dma_en;
   assign engine_enable = run;
   assign engine_power_down = (s_reg.st == ST_OFF);
   assign init_done_indicator = s_reg.init_done;

   read8_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_rd && !host_sel_status && host_size == `DCFHP_SZ8)
      |=> (host_rvalid && host_rdata == {24'h0, $past(sel_hold[23:16])}))
      else $error("byte read returned wrong data");
   read16_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_rd && !host_sel_status && host_size == `DCFHP_SZ16)
      |=> (host_rdata == {16'h0, $past(sel_hold[23:8])}))
      else $error("two-byte read returned wrong data");
   read24_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_rd && !host_sel_status && host_size == `DCFHP_SZ24)
      |=> (host_rdata == {8'h0, $past(sel_hold)}))
      else $error("full read returned wrong data");
   clear_all_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_wr && host_sel_status && host_wdata[7:0] == `DCFHP_ALL_CHANNELS_IRQ_MASK
       && res_load == 2'h0) |=> (data_ready == 2'h0))
      else $error("combined mask did not clear flags");
   flag_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_rd && host_sel_status) |=> ((host_rdata != 32'h0) == ($past(flag) != 2'h0)))
      else $error("status read disagrees with flags");
   start_run_a: assert property (@(posedge clk) disable iff (sys_rst)
      (s_reg.st == ST_OFF && start_cmd && !stop_cmd) ##1 !stop_cmd
      |=> (engine_enable && irq_enable == $past(cfg_irq_en, 2)))
      else $error("start did not apply settings and run");
   stop_down_a: assert property (@(posedge clk) disable iff (sys_rst)
      stop_cmd |=> (engine_power_down && !engine_enable) ##1 (sample_valid == 2'h0))
      else $error("stop did not halt the engine");
   key_reset_a: assert property (@(posedge clk) disable iff (sys_rst)
      $fell(sys_rst) |-> (gen_ch[0].u_chan.s_reg.key == `DCFHP_KEY_HIGH
      && gen_ch[1].u_chan.s_reg.key == `DCFHP_KEY_HIGH))
      else $error("key byte not high after reset");
   set_wins_a: assert property (@(posedge clk) disable iff (sys_rst)
      (clr[0] && res_load[0] && run) |=> data_ready[0])
      else $error("clear beat a new result");
   // checks of host reads, status, settings and sample gating
   status_data_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_rd && host_sel_status)
      |=> (host_rdata == {30'h0, $past(data_ready)}))
      else $error("status read lost a channel flag");
   chan_a_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_wr && host_sel_status && host_wdata[7:0] == `DCFHP_CHANNEL_IRQ_MASK_A
       && res_load == 2'h0) |=> (data_ready == {$past(data_ready[1]), 1'b0}))
      else $error("channel A mask did not clear only its flag");
   chan_b_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (host_wr && host_sel_status && host_wdata[7:0] == `DCFHP_CHANNEL_IRQ_MASK_B
       && res_load == 2'h0) |=> (data_ready == {1'b0, $past(data_ready[0])}))
      else $error("channel B mask did not clear only its flag");
   rvalid_pulse_a: assert property (@(posedge clk) disable iff (sys_rst)
      !host_rd
      |=> !host_rvalid)
      else $error("read answer without a read");
   rdata_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      !host_rd
      |=> $stable(host_rdata))
      else $error("read data changed without a read");
   run_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
      (sample_valid != 2'h0)
      |-> $past(engine_enable))
      else $error("sample handed over outside run");
   off_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!engine_enable && !(host_wr && host_sel_status))
      |=> $stable(data_ready))
      else $error("flag changed while halted");
   cfg_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      !(engine_power_down && start_cmd && !stop_cmd)
      |=> ($stable(irq_enable) && $stable(dma_enable)))
      else $error("settings changed without a start");
   start_cfg_a: assert property (@(posedge clk) disable iff (sys_rst)
      (engine_power_down && start_cmd && !stop_cmd)
      |=> (dma_enable == $past(cfg_dma_en) && init_done_indicator && !engine_power_down))
      else $error("start did not capture settings");
   init_keep_a: assert property (@(posedge clk) disable iff (sys_rst)
      init_done_indicator
      |=> init_done_indicator)
      else $error("init indicator dropped without reset");
endmodule

/* File: bench/dcfhp_engine_model.sv */
// Purpose: filter engine stand-in that echoes each handed sample back as a result
// Assumes: sample_valid is a one-cycle pulse per channel
// Notes: result lines show inverted junk outside a load, so stale values never look valid
`timescale 1ns/1ps
module dcfhp_engine_model
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic enable,
   input wire logic [23:0] sample_a,
   input wire logic [23:0] sample_b,
   input wire logic [1:0] sample_valid,
   output logic [1:0] res_load,
   output logic [23:0] res_data_a,
   output logic [23:0] res_data_b
);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         res_load <= 2'h0;
         res_data_a <= 24'h000000;
         res_data_b <= 24'h000000;
      end else begin
         res_load <= enable ? sample_valid : 2'h0;
         // identity filter keeps two's complement untouched
         res_data_a <= sample_valid[0] ? sample_a : ~res_data_a;
         res_data_b <= sample_valid[1] ? sample_b : ~res_data_b;
      end
   end
endmodule

/* File: bench/dcfhp_top_test.sv */
// Purpose: self-checking bench of the dual channel filter host port
// Assumes: inputs change at the falling edge only
// Notes: engine model echoes samples, so read data equals the expected sample
`timescale 1ns/1ps
`include "dcfhp_params.svh"
module dcfhp_top_test;
   import dcfhp_pkg::*;
   typedef struct packed {logic ch; logic [1:0] sz; logic [23:0] wd; logic [23:0] ex;} dcfhp_row_t;
   logic clk = 1'b0;
   logic sys_rst, start_cmd, stop_cmd, host_chan, host_sel_status, host_wr, host_rd, key_wr;
   logic [1:0] cfg_irq_en, cfg_dma_en, host_size, key_sel, res_load, sample_valid, data_ready;
   logic [1:0] irq_enable, dma_enable;
   logic [31:0] host_wdata, host_rdata, d;
   logic [23:0] res_data_a, res_data_b, sample_a, sample_b;
   logic host_rvalid, engine_enable, engine_power_down, init_done_indicator;
   int fail_count = 0;
   int num_checks = 0;
   dcfhp_row_t r;
   // lower bytes of B are zeroed before its byte-only writes
   dcfhp_row_t rows [6] = '{
      '{1'b0, `DCFHP_SZ24, 24'h123456, 24'h123456},
      '{1'b0, `DCFHP_SZ8, 24'h000080, 24'h803456},
      '{1'b0, `DCFHP_SZ16, 24'h00abcd, 24'habcd56},
      '{1'b1, `DCFHP_SZ24, 24'h000000, 24'h000000},
      '{1'b1, `DCFHP_SZ8, 24'h00007f, 24'h7f0000},
      '{1'b1, `DCFHP_SZ8, 24'h000081, 24'h810000}};
   always #10 clk = ~clk;
   dcfhp_top i_dcfhp_top (.clk(clk), .sys_rst(sys_rst), .start_cmd(start_cmd),
      .stop_cmd(stop_cmd), .cfg_irq_en(cfg_irq_en), .cfg_dma_en(cfg_dma_en),
      .host_chan(host_chan), .host_sel_status(host_sel_status), .host_wr(host_wr),
      .host_rd(host_rd), .host_size(host_size), .host_wdata(host_wdata), .key_wr(key_wr),
      .key_sel(key_sel), .res_load(res_load), .res_data_a(res_data_a),
      .res_data_b(res_data_b), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .sample_a(sample_a), .sample_b(sample_b), .sample_valid(sample_valid),
      .data_ready(data_ready), .irq_enable(irq_enable), .dma_enable(dma_enable),
      .engine_enable(engine_enable), .engine_power_down(engine_power_down),
      .init_done_indicator(init_done_indicator));
   dcfhp_engine_model i_dcfhp_engine_model (.clk(clk), .sys_rst(sys_rst),
      .enable(engine_enable), .sample_a(sample_a), .sample_b(sample_b),
      .sample_valid(sample_valid), .res_load(res_load), .res_data_a(res_data_a),
      .res_data_b(res_data_b));
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // callers never issue two writes back to back, so host_wr is set once per step
   task automatic hwr(input logic ch, input logic st, input logic [1:0] sz, input logic [31:0] v);
      host_chan = ch;
      host_sel_status = st;
      host_size = sz;
      host_wdata = v;
      host_wr = 1'b1;
      @(negedge clk);
      host_wr = 1'b0;
   endtask
   task automatic hrd(input logic ch, input logic st, input logic [1:0] sz);
      host_chan = ch;
      host_sel_status = st;
      host_size = sz;
      host_rd = 1'b1;
      @(negedge clk);
      host_rd = 1'b0;
      chk("rvalid", 32'h1, {31'h0, host_rvalid});
      d = host_rdata;
      @(negedge clk);
   endtask
   task automatic wait_valid(input logic ch);
      for (int i = 0; i < 4 && sample_valid[ch] !== 1'b1; i++) @(negedge clk);
   endtask
   task automatic no_handoff(input logic ch);
      repeat (3) begin
         chk("no_handoff", 32'h0, {31'h0, sample_valid[ch]});
         @(negedge clk);
      end
   endtask
   task automatic set_key(input logic ch, input logic [1:0] k);
      host_chan = ch;
      key_sel = k;
      key_wr = 1'b1;
      @(negedge clk);
      key_wr = 1'b0;
   endtask
   initial begin
      {sys_rst, start_cmd, stop_cmd, host_chan, host_sel_status, host_wr, host_rd} = 7'h40;
      {cfg_irq_en, cfg_dma_en, host_size, key_sel, key_wr} = 9'h000;
      host_wdata = 32'h0;
      repeat (5) @(negedge clk);
      sys_rst = 1'b0;
      chk("power_down", 32'h1, {31'h0, engine_power_down});
      chk("init_done", 32'h0, {31'h0, init_done_indicator});
      chk("ready", 32'h0, {30'h0, data_ready});
      cfg_irq_en = 2'h2;
      cfg_dma_en = 2'h1;
      start_cmd = 1'b1;
      @(negedge clk);
      start_cmd = 1'b0;
      @(negedge clk);
      chk("run", 32'ha, {28'h0, engine_enable, engine_power_down, irq_enable});
      chk("dma_init", 32'h3, {30'h0, dma_enable[0], init_done_indicator});
      foreach (rows[k]) begin
         r = rows[k];
         hwr(r.ch, 1'b0, r.sz, {8'h00, r.wd});
         wait_valid(r.ch);
         chk("sample", {8'h00, r.ex}, {8'h00, r.ch ? sample_b : sample_a});
         repeat (3) @(negedge clk);
         chk("ready", 32'h1, {31'h0, data_ready[r.ch]});
         hrd(r.ch, 1'b0, `DCFHP_SZ8);
         chk("read8", {24'h0, r.ex[23:16]}, d);
         hrd(r.ch, 1'b0, `DCFHP_SZ16);
         chk("read16", {16'h0, r.ex[23:8]}, d);
         hrd(r.ch, 1'b0, `DCFHP_SZ24);
         chk("read24", {8'h0, r.ex}, d);
      end
      hrd(1'b0, 1'b1, `DCFHP_SZ8);
      chk("status", 32'h3, d);
      hwr(1'b0, 1'b1, `DCFHP_SZ8, {24'h0, `DCFHP_CHANNEL_IRQ_MASK_A});
      hrd(1'b0, 1'b1, `DCFHP_SZ8);
      chk("status_a_clr", 32'h2, d);
      hwr(1'b0, 1'b1, `DCFHP_SZ8, {24'h0, `DCFHP_ALL_CHANNELS_IRQ_MASK});
      hrd(1'b0, 1'b1, `DCFHP_SZ8);
      chk("status_all_clr", 32'h0, d);
      // the echoed result lands in the very cycle of a status clear
      hwr(1'b0, 1'b0, `DCFHP_SZ24, 32'h00654321);
      @(negedge clk);
      hwr(1'b0, 1'b1, `DCFHP_SZ8, {24'h0, `DCFHP_CHANNEL_IRQ_MASK_A});
      chk("set_wins", 32'h1, {31'h0, data_ready[0]});
      hrd(1'b0, 1'b0, `DCFHP_SZ24);
      chk("set_wins_data", 32'h00654321, d);
      // low key byte: a top-byte write alone must not reach the engine
      set_key(1'b0, `DCFHP_KEY_LOW);
      hwr(1'b0, 1'b0, `DCFHP_SZ8, 32'h11);
      no_handoff(1'b0);
      hwr(1'b0, 1'b0, `DCFHP_SZ24, 32'h00223344);
      wait_valid(1'b0);
      chk("key_low_sample", 32'h00223344, {8'h00, sample_a});
      set_key(1'b0, `DCFHP_KEY_HIGH);
      stop_cmd = 1'b1;
      @(negedge clk);
      stop_cmd = 1'b0;
      chk("stopped", 32'h3, {30'h0, engine_power_down, init_done_indicator});
      chk("stop_enable", 32'h0, {31'h0, engine_enable});
      hwr(1'b1, 1'b0, `DCFHP_SZ24, 32'h00aaaaaa);
      no_handoff(1'b1);
      // reset after the stop must bring the key byte of B back to high
      set_key(1'b1, `DCFHP_KEY_LOW);
      sys_rst = 1'b1;
      repeat (2) @(negedge clk);
      sys_rst = 1'b0;
      chk("rst_down", 32'h1, {31'h0, engine_power_down});
      chk("rst_init", 32'h0, {31'h0, init_done_indicator});
      chk("rst_ready", 32'h0, {30'h0, data_ready});
      start_cmd = 1'b1;
      @(negedge clk);
      start_cmd = 1'b0;
      @(negedge clk);
      hwr(1'b1, 1'b0, `DCFHP_SZ8, 32'h5a);
      wait_valid(1'b1);
      chk("rst_key", 32'h005a0000, {8'h00, sample_b});
      report_and_stop();
   end
   initial begin
      repeat (2000) @(posedge clk);
      fail_count++;
      report_and_stop();
   end
endmodule
